// File: rtl/ipf_level_arbiter.sv
// Picks the highest effective level among the sources, lowest index wins a tie
`timescale 1ns/1ps
module ipf_level_arbiter #(
  parameter int NUM_SRC = 4,
  parameter int LEVEL_W = 3,
  parameter int SRC_W = 2
) (
  input wire logic [NUM_SRC*LEVEL_W-1:0] levels_in,
  output logic [LEVEL_W-1:0] best_level_out,
  output logic [SRC_W-1:0] best_src_out
);
  always_comb begin
    best_level_out = '0;
    best_src_out = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (levels_in[i*LEVEL_W +: LEVEL_W] > best_level_out) begin
        best_level_out = levels_in[i*LEVEL_W +: LEVEL_W];
        best_src_out = SRC_W'(i);
      end
    end
  end

  generate
    if (NUM_SRC < 1 || NUM_SRC > (1 << SRC_W)) begin : g_bad_count
      $error("ipf_level_arbiter: NUM_SRC does not fit SRC_W");
    end
  endgenerate
endmodule

// File: rtl/ipf_pkg.sv
// Package with register map, field layout and level codes for the priority fields
package ipf_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int LEVEL_W = 3;
  localparam int NUM_SRC = 4;
  localparam int SRC_W = 2;

  // Register offsets
  localparam logic [3:0] OFS_TIMER_EXT = 4'h0;
  localparam logic [3:0] OFS_SPI2 = 4'h1;

  // Field positions (lsb of each 3-bit field)
  localparam int POS_EXT_TWO = 4;
  localparam int POS_TIMER_FIVE = 0;
  localparam int POS_SPI_EVENT = 4;
  localparam int POS_SPI_FAULT = 0;

  // Implemented bits of each register
  localparam logic [15:0] IMPL_MASK = 16'h0077;

  // Level codes
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_MAX = 3'h7;
  localparam logic [2:0] LEVEL_RESET = 3'h4;

  // Source indices
  localparam logic [1:0] SRC_TIMER_FIVE = 2'h0;
  localparam logic [1:0] SRC_EXT_TWO = 2'h1;
  localparam logic [1:0] SRC_SPI_EVENT = 2'h2;
  localparam logic [1:0] SRC_SPI_FAULT = 2'h3;
endpackage

// File: rtl/ipf_priority_regs.sv
// Priority field registers for timer five, external irq two and both SPI2 sources
//
// Overview of operation
// - Code 111 means level 7, the highest
// - Code 001 is level 1; codes map linearly
// - Code 000 disables the source entirely
// - SPI2 register bits 15-7, 3 read zero
`timescale 1ns/1ps
module ipf_priority_regs #(
  parameter int ADDR_W = ipf_pkg::ADDR_W,
  parameter int DATA_W = ipf_pkg::DATA_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic [ipf_pkg::NUM_SRC-1:0] irq_pending_in,
  input wire logic [ipf_pkg::LEVEL_W-1:0] cpu_priority_in,
  output logic [ipf_pkg::NUM_SRC*ipf_pkg::LEVEL_W-1:0] eff_levels_out,
  output logic [ipf_pkg::LEVEL_W-1:0] best_level_out,
  output logic [ipf_pkg::SRC_W-1:0] best_src_out,
  output logic irq_req_out
);
  localparam int LW = ipf_pkg::LEVEL_W;
  localparam int NS = ipf_pkg::NUM_SRC;

  generate
    if (ADDR_W < 4 || DATA_W != 16) begin : g_bad_bus
      $error("ipf_priority_regs: ADDR_W must be at least 4 and DATA_W 16");
    end
  endgenerate

  // Priority fields
  logic [LW-1:0] timer_five_priority;
  logic [LW-1:0] external_irq_two_priority;
  logic [LW-1:0] spi_two_event_priority;
  logic [LW-1:0] spi_two_fault_priority;

  // Pack two fields into one register image, unimplemented bits zero
  function automatic logic [15:0] pack_fields(input logic [LW-1:0] upper, input logic [LW-1:0] lower);
    logic [15:0] img;
    img = 16'h0000;
    img[ipf_pkg::POS_SPI_EVENT +: LW] = upper;
    img[ipf_pkg::POS_SPI_FAULT +: LW] = lower;
    return img & ipf_pkg::IMPL_MASK;
  endfunction

  // Decode of the plain register port
  wire logic hit_timer_ext;
  wire logic hit_spi2;
  wire logic wr_timer_ext;
  wire logic wr_spi2;
  wire logic [15:0] masked_wdata;
  wire logic [15:0] timer_ext_image;
  wire logic [15:0] spi2_image;
  wire logic [15:0] next_rdata;

  assign hit_timer_ext = (addr_in == ADDR_W'(ipf_pkg::OFS_TIMER_EXT));
  assign hit_spi2 = (addr_in == ADDR_W'(ipf_pkg::OFS_SPI2));
  assign wr_timer_ext = wr_in && hit_timer_ext;
  assign wr_spi2 = wr_in && hit_spi2;
  // Writes to unimplemented bits are dropped here
  assign masked_wdata = wdata_in & ipf_pkg::IMPL_MASK;
  assign timer_ext_image = pack_fields(external_irq_two_priority, timer_five_priority);
  assign spi2_image = pack_fields(spi_two_event_priority, spi_two_fault_priority);
  // Unmapped addresses and idle cycles read zero
  assign next_rdata = !rd_in ? 16'h0000 :
                      hit_timer_ext ? timer_ext_image :
                      hit_spi2 ? spi2_image : 16'h0000;

  // Field registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      timer_five_priority <= ipf_pkg::LEVEL_RESET;
      external_irq_two_priority <= ipf_pkg::LEVEL_RESET;
      spi_two_event_priority <= ipf_pkg::LEVEL_RESET;
      spi_two_fault_priority <= ipf_pkg::LEVEL_RESET;
    end else begin
      if (wr_timer_ext) begin
        external_irq_two_priority <= masked_wdata[ipf_pkg::POS_EXT_TWO +: LW];
        timer_five_priority <= masked_wdata[ipf_pkg::POS_TIMER_FIVE +: LW];
      end
      if (wr_spi2) begin
        spi_two_event_priority <= masked_wdata[ipf_pkg::POS_SPI_EVENT +: LW];
        spi_two_fault_priority <= masked_wdata[ipf_pkg::POS_SPI_FAULT +: LW];
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // Effective level per source, in source index order
  wire logic [NS*LW-1:0] field_vec;
  wire logic [NS*LW-1:0] next_eff_levels;
  wire logic [LW-1:0] next_best_level;
  wire logic [ipf_pkg::SRC_W-1:0] next_best_src;
  wire logic next_irq_req;

  assign field_vec = {spi_two_fault_priority, spi_two_event_priority,
                      external_irq_two_priority, timer_five_priority};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_src
      // Level equals code, zero gates the source off
      ipf_src_gate #(
        .LEVEL_W(LW)
      ) u_gate (
        .pending_in(irq_pending_in[g]),
        .level_in(field_vec[g*LW +: LW]),
        .eff_level_out(next_eff_levels[g*LW +: LW])
      );
    end
  endgenerate

  // Highest level wins, level 7 beats every lower level
  ipf_level_arbiter #(
    .NUM_SRC(NS),
    .LEVEL_W(LW),
    .SRC_W(ipf_pkg::SRC_W)
  ) u_arbiter (
    .levels_in(next_eff_levels),
    .best_level_out(next_best_level),
    .best_src_out(next_best_src)
  );

  // Request only above the processor's current level; level 0 never qualifies
  assign next_irq_req = (next_best_level != ipf_pkg::LEVEL_OFF) && (next_best_level > cpu_priority_in);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      eff_levels_out <= '0;
      best_level_out <= ipf_pkg::LEVEL_OFF;
      best_src_out <= '0;
      irq_req_out <= 1'b0;
    end else begin
      eff_levels_out <= next_eff_levels;
      best_level_out <= next_best_level;
      best_src_out <= next_best_src;
      irq_req_out <= next_irq_req;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_spi2_read;
    rd_in && hit_spi2;
  endsequence

  sequence s_spi2_write;
    wr_in && hit_spi2;
  endsequence

  sequence s_only_event_pending;
    irq_pending_in == (NS'(1) << ipf_pkg::SRC_SPI_EVENT);
  endsequence

  sequence s_timer_read;
    rd_in && hit_timer_ext;
  endsequence

  sequence s_timer_write;
    wr_in && hit_timer_ext;
  endsequence

  sequence s_stray_read;
    rd_in && !hit_timer_ext && !hit_spi2;
  endsequence

  sequence s_stray_write;
    wr_in && !hit_timer_ext && !hit_spi2;
  endsequence

  a_max_level_wins: assert property (
    irq_pending_in[ipf_pkg::SRC_SPI_FAULT] && spi_two_fault_priority == ipf_pkg::LEVEL_MAX
    |=> best_level_out == ipf_pkg::LEVEL_MAX && irq_req_out == ($past(cpu_priority_in) != ipf_pkg::LEVEL_MAX)
  ) else $error("level 7 source did not reach level 7");

  a_max_level_src: assert property (
    irq_pending_in == (NS'(1) << ipf_pkg::SRC_SPI_FAULT) && spi_two_fault_priority == ipf_pkg::LEVEL_MAX
    |=> best_src_out == ipf_pkg::SRC_SPI_FAULT && best_level_out == ipf_pkg::LEVEL_MAX
  ) else $error("level 7 source not selected");

  a_min_level_code: assert property (
    s_only_event_pending and (spi_two_event_priority != ipf_pkg::LEVEL_OFF)
    |=> best_level_out == $past(spi_two_event_priority) && best_src_out == ipf_pkg::SRC_SPI_EVENT
  ) else $error("single source level not passed through");

  a_min_level_req: assert property (
    s_only_event_pending and (spi_two_event_priority == ipf_pkg::LEVEL_MIN)
      and (cpu_priority_in == ipf_pkg::LEVEL_OFF)
    |=> irq_req_out
  ) else $error("level 1 source gave no request");

  a_disabled_silent: assert property (
    spi_two_event_priority == ipf_pkg::LEVEL_OFF
    |=> eff_levels_out[ipf_pkg::SRC_SPI_EVENT*LW +: LW] == ipf_pkg::LEVEL_OFF
  ) else $error("disabled source shows a level");

  a_disabled_no_req: assert property (
    field_vec == '0 |=> !irq_req_out && best_level_out == ipf_pkg::LEVEL_OFF
  ) else $error("request with every source disabled");

  a_unimpl_read: assert property (
    s_spi2_read |=> (rdata_out & ~ipf_pkg::IMPL_MASK) == 16'h0000
  ) else $error("unimplemented bits read nonzero");

  a_unimpl_write: assert property (
    s_spi2_write |=> spi2_image == ($past(wdata_in) & ipf_pkg::IMPL_MASK)
  ) else $error("write did not land in implemented bits only");

  a_field_place: assert property (
    s_spi2_read |=> rdata_out[6:4] == $past(spi_two_event_priority)
      && rdata_out[2:0] == $past(spi_two_fault_priority)
  ) else $error("SPI2 fields read at wrong place");

  a_reset_fields: assert property (
    $rose(rst_n_in) |-> spi_two_event_priority == ipf_pkg::LEVEL_RESET
      && spi_two_fault_priority == ipf_pkg::LEVEL_RESET
  ) else $error("SPI2 fields not at reset level");

  a_idle_read_zero: assert property (
    !rd_in |=> rdata_out == 16'h0000
  ) else $error("read data outside read cycle");

  a_req_compare: assert property (
    1'b1 |=> irq_req_out == (best_level_out > $past(cpu_priority_in))
  ) else $error("request not tied to level compare");

  a_req_needs_level: assert property (
    irq_req_out |-> best_level_out != ipf_pkg::LEVEL_OFF
  ) else $error("request raised with no enabled source");

  a_spi2_write_lands: assert property (
    s_spi2_write |=> spi_two_event_priority == $past(wdata_in[ipf_pkg::POS_SPI_EVENT +: LW])
      && spi_two_fault_priority == $past(wdata_in[ipf_pkg::POS_SPI_FAULT +: LW])
  ) else $error("SPI2 write did not reach both fields");

  a_spi2_fields_hold: assert property (
    !(wr_in && hit_spi2) |=> $stable(spi_two_event_priority) && $stable(spi_two_fault_priority)
  ) else $error("SPI2 fields changed without a write");

  a_timer_write_lands: assert property (
    s_timer_write |=> external_irq_two_priority == $past(wdata_in[ipf_pkg::POS_EXT_TWO +: LW])
      && timer_five_priority == $past(wdata_in[ipf_pkg::POS_TIMER_FIVE +: LW])
  ) else $error("timer register write did not reach both fields");

  a_timer_fields_hold: assert property (
    !(wr_in && hit_timer_ext) |=> $stable(external_irq_two_priority) && $stable(timer_five_priority)
  ) else $error("timer register fields changed without a write");

  a_timer_field_place: assert property (
    s_timer_read |=> rdata_out[ipf_pkg::POS_EXT_TWO +: LW] == $past(external_irq_two_priority)
      && rdata_out[ipf_pkg::POS_TIMER_FIVE +: LW] == $past(timer_five_priority)
      && (rdata_out & ~ipf_pkg::IMPL_MASK) == 16'h0000
  ) else $error("timer register fields read at wrong place");

  a_stray_read_zero: assert property (
    s_stray_read |=> rdata_out == 16'h0000
  ) else $error("unmapped address read nonzero");

  a_stray_write_void: assert property (
    s_stray_write |=> field_vec == $past(field_vec)
  ) else $error("unmapped write changed a field");

  a_best_src_match: assert property (
    best_level_out != ipf_pkg::LEVEL_OFF |-> eff_levels_out[best_src_out*LW +: LW] == best_level_out
  ) else $error("best source does not carry the best level");

  // Per-source checks on the registered levels
  generate
    for (genvar k = 0; k < NS; k++) begin : g_chk
      a_level_follows: assert property (
        rst_n_in && irq_pending_in[k] |=> eff_levels_out[k*LW +: LW] == $past(field_vec[k*LW +: LW])
      ) else $error("pending source level differs from its code");

      a_level_gated: assert property (
        !irq_pending_in[k] |=> eff_levels_out[k*LW +: LW] == ipf_pkg::LEVEL_OFF
      ) else $error("idle source shows a level");

      a_best_covers: assert property (
        eff_levels_out[k*LW +: LW] <= best_level_out
      ) else $error("best level below a source level");

      a_tie_lowest: assert property (
        (k < best_src_out) |-> eff_levels_out[k*LW +: LW] < best_level_out
      ) else $error("tie not given to the lowest index");
    end
  endgenerate
endmodule

// File: rtl/ipf_src_gate.sv
// Gate that turns a pending source and its priority field into an effective level
`timescale 1ns/1ps
module ipf_src_gate #(
  parameter int LEVEL_W = 3
) (
  input wire logic pending_in,
  input wire logic [LEVEL_W-1:0] level_in,
  output logic [LEVEL_W-1:0] eff_level_out
);
  wire logic enabled;

  // Code maps straight to level; zero means no request at all
  assign enabled = (level_in != '0);
  assign eff_level_out = (pending_in && enabled) ? level_in : '0;

  generate
    if (LEVEL_W < 1) begin : g_bad_width
      $error("ipf_src_gate: LEVEL_W must be at least 1");
    end
  endgenerate
endmodule

// File: testbench/interrupt_priority_fields_bench.sv
// Self-checking bench for the priority field registers and the request path
`timescale 1ns/1ps
module interrupt_priority_fields_bench;
  typedef struct {
    logic [15:0] reg0;
    logic [15:0] reg1;
    logic [3:0] pend;
    logic [2:0] cpu;
    logic [11:0] eff;
    logic [2:0] best;
    logic [1:0] src;
    logic req;
  } ipf_row_t;

  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [3:0] irq_pending_in = 4'h0;
  logic [2:0] cpu_priority_in = 3'h0;
  logic [11:0] eff_levels_out;
  logic [2:0] best_level_out;
  logic [1:0] best_src_out;
  logic irq_req_out;
  int failures = 0;
  int n_tests = 0;
  ipf_row_t rows [8];

  ipf_priority_regs i_dut (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .irq_pending_in(irq_pending_in),
    .cpu_priority_in(cpu_priority_in),
    .eff_levels_out(eff_levels_out),
    .best_level_out(best_level_out),
    .best_src_out(best_src_out),
    .irq_req_out(irq_req_out)
  );

  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stands one cycle only, then must drop to zero
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk("rdata_out", e, rdata_out);
    @(posedge sys_clk_in);
    #1 chk("rdata_out idle", 16'h0000, rdata_out);
  endtask

  task automatic path(input logic [3:0] p, input logic [2:0] c, input logic [11:0] e,
                      input logic [2:0] b, input logic [1:0] s, input logic q);
    @(posedge sys_clk_in);
    irq_pending_in <= p;
    cpu_priority_in <= c;
    repeat (3) @(posedge sys_clk_in);
    #1 chk("eff_levels_out", {4'h0, e}, {4'h0, eff_levels_out});
    chk("best_level_out", {13'h0000, b}, {13'h0000, best_level_out});
    chk("best_src_out", {14'h0000, s}, {14'h0000, best_src_out});
    chk("irq_req_out", {15'h0000, q}, {15'h0000, irq_req_out});
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    stop_test();
  end

  initial begin
    rows[0] = '{16'h0071, 16'h0023, 4'hf, 3'h0, 12'h6b9, 3'h7, 2'h1, 1'b1};
    rows[1] = '{16'h0070, 16'h0070, 4'hf, 3'h7, 12'h1f8, 3'h7, 2'h1, 1'b0};
    rows[2] = '{16'h0000, 16'h0065, 4'h4, 3'h5, 12'h180, 3'h6, 2'h2, 1'b1};
    rows[3] = '{16'h0034, 16'h0007, 4'h1, 3'h4, 12'h004, 3'h4, 2'h0, 1'b0};
    rows[4] = '{16'h0000, 16'h0000, 4'hf, 3'h0, 12'h000, 3'h0, 2'h0, 1'b0};
    rows[5] = '{16'h0000, 16'h0011, 4'hc, 3'h0, 12'h240, 3'h1, 2'h2, 1'b1};
    rows[6] = '{16'h0000, 16'h0017, 4'h8, 3'h0, 12'he00, 3'h7, 2'h3, 1'b1};
    rows[7] = '{16'h0000, 16'h0017, 4'h4, 3'h0, 12'h040, 3'h1, 2'h2, 1'b1};
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(ipf_pkg::OFS_SPI2, 16'h0044);
    rd(ipf_pkg::OFS_TIMER_EXT, 16'h0044);
    path(4'hf, 3'h3, 12'h924, 3'h4, 2'h0, 1'b1);
    foreach (rows[i]) begin
      wr(ipf_pkg::OFS_TIMER_EXT, rows[i].reg0);
      wr(ipf_pkg::OFS_SPI2, rows[i].reg1);
      path(rows[i].pend, rows[i].cpu, rows[i].eff, rows[i].best, rows[i].src, rows[i].req);
      rd(ipf_pkg::OFS_SPI2, rows[i].reg1);
    end
    wr(ipf_pkg::OFS_SPI2, 16'hffff);
    rd(ipf_pkg::OFS_SPI2, 16'h0077);
    path(4'hc, 3'h6, 12'hfc0, 3'h7, 2'h2, 1'b1);
    wr(ipf_pkg::OFS_SPI2, 16'hff88);
    rd(ipf_pkg::OFS_SPI2, 16'h0000);
    path(4'hc, 3'h0, 12'h000, 3'h0, 2'h0, 1'b0);
    wr(4'h5, 16'h0077);
    rd(4'h5, 16'h0000);
    rd(ipf_pkg::OFS_SPI2, 16'h0000);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    irq_pending_in <= 4'hf;
    @(posedge sys_clk_in);
    #1 chk("irq_req_out in reset", 16'h0000, {15'h0000, irq_req_out});
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(ipf_pkg::OFS_SPI2, 16'h0044);
    path(4'h8, 3'h3, 12'h800, 3'h4, 2'h3, 1'b1);
    stop_test();
  end
endmodule
